// [mpcfg_top.sv]
// Mode-pin strap capture and live power-down / direction gating.
// Assumes pins are asynchronous; reset is synchronous active low.
// Operation
// - Straps captured at reset release, held
// - Rx power-down stops Rx clocks, fast analog
// - Tx power-down stops Tx clocks, keeps PLL
// - Power-down pins are live levels always
// - Half-duplex high: Rx clocks off, bus input
// - Half-duplex low: Tx clock off, bus drives unless Rx powered down
// - Direction gates only digital clocks and bus drive
// - Low-power strap high cuts ADC power
// - Chip-select low at reset enables straps
// - Duplex strap low selects half duplex
// - Width strap low parallel, high interleaved
// - Interp straps set interpolation and PLL
`timescale 1ns/1ps
`default_nettype none
module mpcfg_top (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic serial_cs_pin_in,
  input wire logic serial_data_in_pin_in,
  input wire logic serial_clk_pin_in,
  input wire logic serial_data_out_pin_in,
  input wire logic iface_pin_two_in,
  input wire logic adc_low_power_strap_in,
  input wire logic rx_powerdown_pin_in,
  input wire logic tx_powerdown_pin_in,
  input wire logic iface_pin_one_in,
  output logic serial_port_en_out,
  output var mpcfg_pkg::mpcfg_bus_t bus_mode_out,
  output logic [1:0] interp_factor_out,
  output logic [1:0] pll_mult_out,
  output logic adc_low_power_out,
  output logic rx_clk_en_out,
  output logic adc_clk_en_out,
  output logic tx_clk_en_out,
  output logic dac_clk_en_out,
  output logic pll_run_out,
  output logic rx_analog_on_out,
  output logic tx_analog_on_out,
  output logic bus_drive_en_out
);
  import mpcfg_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [8:0] pins_s;
  mpcfg_sync #(.WIDTH(9)) u_sync (
    .clk_in(clk_in),
    .d_in({serial_cs_pin_in, serial_data_in_pin_in, serial_clk_pin_in,
           serial_data_out_pin_in, iface_pin_two_in,
           adc_low_power_strap_in, rx_powerdown_pin_in,
           tx_powerdown_pin_in, iface_pin_one_in}),
    .q_out(pins_s)
  );
  logic cs_s, interp_hi_s, interp_lo_s, duplex_s, width_s, lowpwr_s;
  logic rxpd_s, txpd_s, dir_s;
  assign {cs_s, interp_hi_s, interp_lo_s, duplex_s, width_s, lowpwr_s,
          rxpd_s, txpd_s, dir_s} = pins_s;

  ////////////////////////////////////////////////////////////////////////
  // Strap capture: first clocked cycle after reset release
  logic captured_r, captured_nxt;
  logic spi_en_r, spi_en_nxt;
  mpcfg_bus_t bus_r, bus_nxt;
  logic [1:0] interp_r, interp_nxt;
  logic lowpwr_r, lowpwr_nxt;

  // Decode the strap set into a bus mode
  function automatic mpcfg_bus_t bus_decode(input logic spi,
                                            input logic fd,
                                            input logic w10);
    if (spi)
      return MPCFG_BUS_SERIAL;
    else if (fd)
      return MPCFG_BUS_FD;
    else if (w10)
      return MPCFG_BUS_HD_INTERLEAVED;
    else
      return MPCFG_BUS_HD_PARALLEL;
  endfunction

  // Captured once, held until next reset; host keeps cs steady
  always_comb begin
    captured_nxt = 1'h1;
    spi_en_nxt = spi_en_r;
    bus_nxt = bus_r;
    interp_nxt = interp_r;
    lowpwr_nxt = lowpwr_r;
    if (!captured_r) begin
      spi_en_nxt = cs_s;
      bus_nxt = bus_decode(cs_s, duplex_s, width_s);
      lowpwr_nxt = lowpwr_s;
      // Interp straps ignored when the serial port owns the config
      interp_nxt = cs_s ? MPCFG_RST_INTERP
                        : {interp_hi_s, interp_lo_s};
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      captured_r <= 1'h0;
      spi_en_r <= MPCFG_RST_SPI_EN;
      bus_r <= MPCFG_BUS_FD;
      interp_r <= MPCFG_RST_INTERP;
      lowpwr_r <= MPCFG_RST_LOW_POWER;
    end else begin
      captured_r <= captured_nxt;
      spi_en_r <= spi_en_nxt;
      bus_r <= bus_nxt;
      interp_r <= interp_nxt;
      lowpwr_r <= lowpwr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Live gating from power-down and direction pins
  logic half_duplex;
  assign half_duplex = (bus_r == MPCFG_BUS_HD_PARALLEL) ||
                       (bus_r == MPCFG_BUS_HD_INTERLEAVED);
  logic rx_clk_r, rx_clk_nxt, tx_clk_r, tx_clk_nxt;
  logic rx_an_r, rx_an_nxt, tx_an_r, tx_an_nxt, drv_r, drv_nxt;

  // Levels only; never latched, so they track pins with sync delay
  always_comb begin
    rx_clk_nxt = !rxpd_s && !(half_duplex && dir_s);
    tx_clk_nxt = !txpd_s && !(half_duplex && !dir_s);
    rx_an_nxt = !rxpd_s;
    tx_an_nxt = !txpd_s;
    // Bus drives only for Rx output in half duplex, Rx path alive
    drv_nxt = half_duplex && !dir_s && !rxpd_s;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rx_clk_r <= 1'h0;
      tx_clk_r <= 1'h0;
      rx_an_r <= 1'h0;
      tx_an_r <= 1'h0;
      drv_r <= 1'h0;
    end else begin
      rx_clk_r <= rx_clk_nxt;
      tx_clk_r <= tx_clk_nxt;
      rx_an_r <= rx_an_nxt;
      tx_an_r <= tx_an_nxt;
      drv_r <= drv_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops
  assign serial_port_en_out = spi_en_r;
  assign bus_mode_out = bus_r;
  assign interp_factor_out = interp_r;
  assign pll_mult_out = interp_r;
  assign adc_low_power_out = lowpwr_r;
  assign rx_clk_en_out = rx_clk_r;
  assign adc_clk_en_out = rx_clk_r;
  assign tx_clk_en_out = tx_clk_r;
  assign dac_clk_en_out = tx_clk_r;
  assign pll_run_out = captured_r;
  assign rx_analog_on_out = rx_an_r;
  assign tx_analog_on_out = tx_an_r;
  assign bus_drive_en_out = drv_r;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_hold;
    @(posedge clk_in) disable iff (!rst_n_in)
      captured_r && $past(captured_r) |-> $stable(bus_r) && $stable(interp_r);
  endproperty
  a_hold: assert property (p_hold) else $error("config changed");

  property p_rxpd;
    @(posedge clk_in) disable iff (!rst_n_in)
      rx_powerdown_pin_in [*4] |-> !rx_clk_en_out && !rx_analog_on_out;
  endproperty
  a_rxpd: assert property (p_rxpd) else $error("rx not down");

  property p_txpd;
    @(posedge clk_in) disable iff (!rst_n_in)
      tx_powerdown_pin_in [*4] |-> !tx_clk_en_out && !tx_analog_on_out;
  endproperty
  a_txpd: assert property (p_txpd) else $error("tx not down");

  property p_live;
    @(posedge clk_in) disable iff (!rst_n_in)
      !rx_powerdown_pin_in [*4] ##0 half_duplex == 1'h0 |-> rx_clk_en_out;
  endproperty
  a_live: assert property (p_live) else $error("rx gated");

  property p_hd_tx;
    @(posedge clk_in) disable iff (!rst_n_in)
      iface_pin_one_in [*4] ##0 half_duplex |-> !rx_clk_en_out
        && !bus_drive_en_out;
  endproperty
  a_hd_tx: assert property (p_hd_tx) else $error("hd tx dir");

  property p_hd_rx;
    @(posedge clk_in) disable iff (!rst_n_in)
      !iface_pin_one_in [*4] ##0 half_duplex |-> !tx_clk_en_out;
  endproperty
  a_hd_rx: assert property (p_hd_rx) else $error("hd rx dir");

  property p_analog;
    @(posedge clk_in) disable iff (!rst_n_in)
      !rx_powerdown_pin_in [*4] |-> rx_analog_on_out;
  endproperty
  a_analog: assert property (p_analog) else $error("analog off");

  // Capture shows one edge later; the pins it used lie three samples back
  property p_pll;
    @(posedge clk_in) disable iff (!rst_n_in)
      $rose(captured_r) && !serial_port_en_out |->
        pll_mult_out == $past({serial_data_in_pin_in, serial_clk_pin_in}, 3)
        && interp_factor_out == pll_mult_out && pll_run_out;
  endproperty
  a_pll: assert property (p_pll) else $error("pll mismatch");

  property p_spi;
    @(posedge clk_in) disable iff (!rst_n_in)
      captured_r && serial_port_en_out |-> bus_mode_out == MPCFG_BUS_SERIAL;
  endproperty
  a_spi: assert property (p_spi) else $error("serial mode");

  c_fd: cover property (@(posedge clk_in) bus_r == MPCFG_BUS_FD && captured_r);
  c_half_duplex_interleaved_mode: cover property (@(posedge clk_in) bus_r == MPCFG_BUS_HD_INTERLEAVED);
  c_half_duplex_parallel_mode: cover property (@(posedge clk_in) bus_r == MPCFG_BUS_HD_PARALLEL);
  c_drv: cover property (@(posedge clk_in) bus_drive_en_out);
endmodule
`default_nettype wire

// [mpcfg_pkg.sv]
// Package for the mode-pin configuration and power-down block.
// Assumes a single 40 MHz clock domain; no bus, all controls are ports.
package mpcfg_pkg;
  // Interpolation / PLL factor codes
  localparam logic [1:0] MPCFG_INTERP_1X = 2'h0;
  localparam logic [1:0] MPCFG_INTERP_2X = 2'h1;
  localparam logic [1:0] MPCFG_INTERP_4X = 2'h2;
  // Reset values of the captured configuration
  localparam logic MPCFG_RST_SPI_EN = 1'h0;
  localparam logic MPCFG_RST_FULL_DUPLEX = 1'h1;
  localparam logic MPCFG_RST_INTERLEAVED = 1'h0;
  localparam logic MPCFG_RST_LOW_POWER = 1'h0;
  localparam logic [1:0] MPCFG_RST_INTERP = 2'h0;
  // Restart time bound of analog circuits switched off by power-down, in us
  localparam int MPCFG_FAST_RESTART_US = 10;
  localparam int MPCFG_CLK_MHZ = 40;
  localparam int MPCFG_FAST_RESTART_CYC =
    MPCFG_FAST_RESTART_US * MPCFG_CLK_MHZ;
  // Bus configuration modes
  typedef enum logic [1:0] {
    MPCFG_BUS_FD,
    MPCFG_BUS_HD_PARALLEL,
    MPCFG_BUS_HD_INTERLEAVED,
    MPCFG_BUS_SERIAL
  } mpcfg_bus_t;
endpackage

// [mpcfg_sync.sv]
// Two-flop synchroniser for asynchronous pin levels.
// Assumes clk_in is the only clock; first stage read only by second.
`timescale 1ns/1ps
`default_nettype none
module mpcfg_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] q_r;
  logic [WIDTH-1:0] q_nxt;

  // Next values of both stages
  always_comb begin
    meta_nxt = d_in;
    q_nxt = meta_r;
  end

  // No reset: stages keep sampling through reset, so the straps are
  // already settled at the capture edge and no false low follows release
  always_ff @(posedge clk_in) begin
    meta_r <= meta_nxt;
    q_r <= q_nxt;
  end

  assign q_out = q_r;
endmodule
`default_nettype wire

// [mpcfg_strap_host.sv]
// Board strap and host model that drives every mode pin of the block.
// Assumes the bench hands it pin levels on a falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module mpcfg_strap_host (
  input wire logic clk_in,
  input wire logic [5:0] strap_req_in,
  input wire logic [2:0] live_req_in,
  output var logic cs_out = 1'b0,
  output var logic [1:0] interp_out = 2'h0,
  output var logic duplex_out = 1'b0,
  output var logic width_out = 1'b0,
  output var logic low_power_out = 1'b0,
  output var logic [2:0] live_out = 3'h0
);
  // Pins move on the falling edge only, clear of the capture edge
  always @(negedge clk_in) begin
    cs_out <= strap_req_in[5];
    interp_out <= strap_req_in[4:3];
    duplex_out <= strap_req_in[2];
    width_out <= strap_req_in[1];
    low_power_out <= strap_req_in[0];
    live_out <= live_req_in;
  end
endmodule
`default_nettype wire

// [mpcfg_top_bench.sv]
// Self-checking bench for the strap capture and power-down block.
// Assumes the strap host model; one 40 MHz clock, sync active-low reset.
`timescale 1ns/1ps
`default_nettype none
module mpcfg_top_bench;
  import mpcfg_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [5:0] strap_req = 6'h00;
  logic [2:0] live_req = 3'h0;
  logic cs, duplex, width, low_power;
  logic [1:0] interp, interp_f, pll_mult;
  logic [2:0] live;
  logic spi_en, adc_lp, rx_en, adc_en, tx_en, dac_en;
  logic pll_run, rx_an, tx_an, drv;
  mpcfg_bus_t bus_mode;
  int errors = 0;
  int check_count = 0;
  // Strap sets: {cs, interp[1:0], duplex, width, low power}
  localparam logic [5:0] CFGS [5] = '{6'h0C, 6'h01, 6'h12, 6'h0F, 6'h33};
  ////////////////////////////////////////////////////////////////////////
  mpcfg_strap_host host (.clk_in(clk_in), .strap_req_in(strap_req),
    .live_req_in(live_req), .cs_out(cs), .interp_out(interp),
    .duplex_out(duplex), .width_out(width), .low_power_out(low_power),
    .live_out(live));
  mpcfg_top DUT (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .serial_cs_pin_in(cs), .serial_data_in_pin_in(interp[1]),
    .serial_clk_pin_in(interp[0]), .serial_data_out_pin_in(duplex),
    .iface_pin_two_in(width), .adc_low_power_strap_in(low_power),
    .rx_powerdown_pin_in(live[2]), .tx_powerdown_pin_in(live[1]),
    .iface_pin_one_in(live[0]), .serial_port_en_out(spi_en),
    .bus_mode_out(bus_mode), .interp_factor_out(interp_f),
    .pll_mult_out(pll_mult), .adc_low_power_out(adc_lp),
    .rx_clk_en_out(rx_en), .adc_clk_en_out(adc_en),
    .tx_clk_en_out(tx_en), .dac_clk_en_out(dac_en),
    .pll_run_out(pll_run), .rx_analog_on_out(rx_an),
    .tx_analog_on_out(tx_an), .bus_drive_en_out(drv));
  ////////////////////////////////////////////////////////////////////////
  // Free-running 25 ns clock
  initial begin
    forever #12.5 clk_in = ~clk_in;
  end
  task automatic cycles(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic chk(input string what, input logic [3:0] exp,
                     input logic [3:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Walk every power-down and direction level; pins are live levels
  task automatic t_live(input logic hd);
    logic rx, tx;
    for (int i = 0; i < 8; i++) begin
      live_req <= i[2:0];
      cycles(5);
      rx = !i[2] && !(hd && i[0]);
      tx = !i[1] && !(hd && !i[0]);
      chk("clock enables", {rx, rx, tx, tx},
          {rx_en, adc_en, tx_en, dac_en});
      chk("analog and bus", {1'b1, !i[2], !i[1], hd && !i[0] && !i[2]},
          {pll_run, rx_an, tx_an, drv});
    end
    live_req <= 3'h0;
  endtask
  // Reset with a strap set, check the capture, then disturb the straps
  task automatic t_cfg(input logic [5:0] s);
    logic ser;
    mpcfg_bus_t mode;
    logic [1:0] itp;
    ser = s[5];
    mode = ser ? MPCFG_BUS_SERIAL : (s[2] ? MPCFG_BUS_FD :
           (s[1] ? MPCFG_BUS_HD_INTERLEAVED : MPCFG_BUS_HD_PARALLEL));
    itp = ser ? MPCFG_INTERP_1X : s[4:3];
    strap_req <= s;
    rst_n_in <= 1'b0;
    cycles(6);
    rst_n_in <= 1'b1;
    cycles(4);
    for (int k = 0; k < 2; k++) begin
      chk("serial enable", {3'h0, ser}, {3'h0, spi_en});
      chk("bus mode", {2'h0, mode}, {2'h0, bus_mode});
      chk("interp and pll", {itp, itp}, {interp_f, pll_mult});
      // Low-power strap has its own pin, so it is taken in every mode
      chk("adc low power", {3'h0, s[0]}, {3'h0, adc_lp});
      // Chip-select stays put; only the other straps flip
      strap_req <= {s[5], ~s[4:0]};
      cycles(4);
    end
    if (!ser) begin
      t_live(!s[2]);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence over all strap sets
  initial begin
    cycles(1);
    for (int c = 0; c < 5; c++) begin
      t_cfg(CFGS[c]);
    end
    stop_test();
  end
  // Watchdog well beyond the roughly 250 cycles the tests need
  initial begin
    repeat (4000) @(posedge clk_in);
    errors++;
    stop_test();
  end
endmodule
`default_nettype wire
